// ---- rtl/cia_defines.vh ----
// Constants for the controller identify attribute block
`ifndef CIA_DEFINES_VH
`define CIA_DEFINES_VH
`define CIA_REG_FMT 12'h20C
`define CIA_REG_CACHE 12'h20D
`define CIA_REG_AWN 12'h20E
`define CIA_REG_AWP 12'h20F
`define CIA_REG_NPS 12'h210
`define CIA_REG_PSIDX 12'h211
`define CIA_REG_PSMP 12'h212
`define CIA_REG_PSEN 12'h213
`define CIA_REG_PSEX 12'h214
`define CIA_REG_PSREL 12'h215
`define CIA_REG_VSIDX 12'h216
`define CIA_REG_VSDAT 12'h217
`define CIA_REG_RDADDR 12'h218
`define CIA_REG_RDDATA 12'h219
`define CIA_BYTE_FMT 12'h20C
`define CIA_BYTE_CACHE 12'h20D
`define CIA_BYTE_AWN_LO 12'h20E
`define CIA_BYTE_AWN_HI 12'h20F
`define CIA_BYTE_AWP_LO 12'h210
`define CIA_BYTE_AWP_HI 12'h211
`define CIA_BYTE_NPS 12'h107
`define CIA_PSD_BASE 12'h800
`define CIA_PSD_END 12'hBFF
`define CIA_VS_BASE 12'hC00
`define CIA_FMT_MASK 8'h07
`define CIA_CACHE_MASK 8'h01
`define CIA_AWN_RESET 16'h00FF
`define CIA_AWP_RESET 16'h0000
`define CIA_REL_MASK 5'h1F
`endif

// ---- rtl/cia_identify_attr.v ----
// Controller identify attribute area: upper structure bytes and power state descriptors
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`include "cia_defines.vh"
`default_nettype none
module cia_identify_attr #(
	parameter VS_WORDS = 256
) (
	input wire clk_sys_in,
	input wire resetn_in,
	input wire [11:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	output reg write_cache_present_out,
	output reg [15:0] atomic_unit_normal_out,
	output reg [15:0] atomic_unit_powerfail_out
);
	reg [7:0] format_attributes_byte_q;
	reg [7:0] write_cache_present_byte_q;
	reg [15:0] atomic_unit_normal_q;
	reg [15:0] atomic_unit_powerfail_q;
	reg [4:0] power_state_count_q;
	reg [4:0] ps_idx_q;
	reg [7:0] vs_idx_q;
	reg [11:0] rd_addr_q;
	reg [15:0] max_power_field [0:31];
	reg [31:0] entry_latency_field [0:31];
	reg [31:0] exit_latency_field [0:31];
	reg [19:0] rel_rank [0:31];
	reg [31:0] vs_mem [0:VS_WORDS-1];
	reg [31:0] rdata_d;
	integer i;

	// Clamp a ranking to no more than the supported count
	function [4:0] cia_rank;
		input [4:0] v;
		input [4:0] cnt;
		begin
			cia_rank = (v > cnt) ? cnt : v;
		end
	endfunction

	// One byte of a power state descriptor
	function [7:0] cia_psd_byte;
		input [4:0] b;
		input [15:0] mp;
		input [31:0] en;
		input [31:0] ex;
		input [19:0] rl;
		begin
			case (b)
				5'h00: cia_psd_byte = mp[7:0];
				5'h01: cia_psd_byte = mp[15:8];
				5'h02: cia_psd_byte = 8'h00;
				5'h03: cia_psd_byte = 8'h00;
				5'h04: cia_psd_byte = en[7:0];
				5'h05: cia_psd_byte = en[15:8];
				5'h06: cia_psd_byte = en[23:16];
				5'h07: cia_psd_byte = en[31:24];
				5'h08: cia_psd_byte = ex[7:0];
				5'h09: cia_psd_byte = ex[15:8];
				5'h0A: cia_psd_byte = ex[23:16];
				5'h0B: cia_psd_byte = ex[31:24];
				5'h0C: cia_psd_byte = {3'h0, rl[4:0]};
				5'h0D: cia_psd_byte = {3'h0, rl[9:5]};
				5'h0E: cia_psd_byte = {3'h0, rl[14:10]};
				5'h0F: cia_psd_byte = {3'h0, rl[19:15]};
				5'h10: cia_psd_byte = 8'h00;
				5'h11: cia_psd_byte = 8'h00;
				5'h12: cia_psd_byte = 8'h00;
				5'h13: cia_psd_byte = 8'h00;
				5'h14: cia_psd_byte = 8'h00;
				5'h15: cia_psd_byte = 8'h00;
				5'h16: cia_psd_byte = 8'h00;
				5'h17: cia_psd_byte = 8'h00;
				5'h18: cia_psd_byte = 8'h00;
				5'h19: cia_psd_byte = 8'h00;
				5'h1A: cia_psd_byte = 8'h00;
				5'h1B: cia_psd_byte = 8'h00;
				5'h1C: cia_psd_byte = 8'h00;
				5'h1D: cia_psd_byte = 8'h00;
				5'h1E: cia_psd_byte = 8'h00;
				5'h1F: cia_psd_byte = 8'h00;
				default: cia_psd_byte = 8'h00;
			endcase
		end
	endfunction

	// Byte of the structure at rd_addr_q
	reg [7:0] struct_byte;
	reg [4:0] ps_sel;
	reg [31:0] vs_word;
	reg [19:0] rl_view;
	always @*
	begin
		ps_sel = rd_addr_q[9:5];
		vs_word = vs_mem[rd_addr_q[9:2] % VS_WORDS];
		// Rankings clamped again in case the count shrank after they were written
		rl_view = {
			cia_rank(rel_rank[ps_sel][19:15], power_state_count_q),
			cia_rank(rel_rank[ps_sel][14:10], power_state_count_q),
			cia_rank(rel_rank[ps_sel][9:5], power_state_count_q),
			cia_rank(rel_rank[ps_sel][4:0], power_state_count_q)};
		struct_byte = 8'h00;
		if (rd_addr_q == `CIA_BYTE_FMT)
		begin
			struct_byte = format_attributes_byte_q;
		end
		else if (rd_addr_q == `CIA_BYTE_CACHE)
		begin
			struct_byte = write_cache_present_byte_q;
		end
		else if (rd_addr_q == `CIA_BYTE_AWN_LO)
		begin
			struct_byte = atomic_unit_normal_q[7:0];
		end
		else if (rd_addr_q == `CIA_BYTE_AWN_HI)
		begin
			struct_byte = atomic_unit_normal_q[15:8];
		end
		else if (rd_addr_q == `CIA_BYTE_AWP_LO)
		begin
			struct_byte = atomic_unit_powerfail_q[7:0];
		end
		else if (rd_addr_q == `CIA_BYTE_AWP_HI)
		begin
			struct_byte = atomic_unit_powerfail_q[15:8];
		end
		else if (rd_addr_q == `CIA_BYTE_NPS)
		begin
			struct_byte = {3'h0, power_state_count_q};
		end
		else if (rd_addr_q >= `CIA_PSD_BASE && rd_addr_q <= `CIA_PSD_END)
		begin
			if (ps_sel <= power_state_count_q)
				struct_byte = cia_psd_byte(rd_addr_q[4:0], max_power_field[ps_sel],
					entry_latency_field[ps_sel], exit_latency_field[ps_sel],
					rl_view);
		end
		else if (rd_addr_q >= `CIA_VS_BASE)
		begin
			case (rd_addr_q[1:0])
				2'h0:
				begin
					struct_byte = vs_word[7:0];
				end
				2'h1:
				begin
					struct_byte = vs_word[15:8];
				end
				2'h2:
				begin
					struct_byte = vs_word[23:16];
				end
				default:
				begin
					struct_byte = vs_word[31:24];
				end
			endcase
		end
	end

	// Read mux
	always @*
	begin
		rdata_d = 32'h0000_0000;
		case (reg_addr_in)
			`CIA_REG_FMT:
			begin
				rdata_d = {24'h0, format_attributes_byte_q};
			end
			`CIA_REG_CACHE:
			begin
				rdata_d = {24'h0, write_cache_present_byte_q};
			end
			`CIA_REG_AWN:
			begin
				rdata_d = {16'h0, atomic_unit_normal_q};
			end
			`CIA_REG_AWP:
			begin
				rdata_d = {16'h0, atomic_unit_powerfail_q};
			end
			`CIA_REG_NPS:
			begin
				rdata_d = {27'h0, power_state_count_q};
			end
			`CIA_REG_PSIDX:
			begin
				rdata_d = {27'h0, ps_idx_q};
			end
			`CIA_REG_PSMP:
			begin
				rdata_d = {16'h0, max_power_field[ps_idx_q]};
			end
			`CIA_REG_PSEN:
			begin
				rdata_d = entry_latency_field[ps_idx_q];
			end
			`CIA_REG_PSEX:
			begin
				rdata_d = exit_latency_field[ps_idx_q];
			end
			`CIA_REG_PSREL:
			begin
				rdata_d = {12'h0, rel_rank[ps_idx_q]};
			end
			`CIA_REG_VSIDX:
			begin
				rdata_d = {24'h0, vs_idx_q};
			end
			`CIA_REG_VSDAT:
			begin
				rdata_d = vs_mem[vs_idx_q % VS_WORDS];
			end
			`CIA_REG_RDADDR:
			begin
				rdata_d = {20'h0, rd_addr_q};
			end
			`CIA_REG_RDDATA:
			begin
				rdata_d = {24'h0, struct_byte};
			end
			default:
			begin
				rdata_d = 32'h0000_0000;
			end
		endcase
	end

	// Control registers and outputs
	always @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			format_attributes_byte_q <= 8'h00;
			write_cache_present_byte_q <= 8'h00;
			atomic_unit_normal_q <= `CIA_AWN_RESET;
			atomic_unit_powerfail_q <= `CIA_AWP_RESET;
			power_state_count_q <= 5'h00;
			ps_idx_q <= 5'h00;
			vs_idx_q <= 8'h00;
			rd_addr_q <= 12'h000;
			reg_rdata_out <= 32'h0000_0000;
			write_cache_present_out <= 1'b0;
			atomic_unit_normal_out <= `CIA_AWN_RESET;
			atomic_unit_powerfail_out <= `CIA_AWP_RESET;
		end
		else
		begin
			reg_rdata_out <= reg_rd_in ? rdata_d : 32'h0000_0000;
			write_cache_present_out <= write_cache_present_byte_q[0];
			atomic_unit_normal_out <= atomic_unit_normal_q;
			atomic_unit_powerfail_out <= atomic_unit_powerfail_q;
			if (reg_wr_in)
			begin
				case (reg_addr_in)
					`CIA_REG_FMT:
					begin
						format_attributes_byte_q <= reg_wdata_in[7:0] & `CIA_FMT_MASK;
					end
					`CIA_REG_CACHE:
					begin
						write_cache_present_byte_q <= reg_wdata_in[7:0] & `CIA_CACHE_MASK;
					end
					`CIA_REG_AWN:
					begin
						atomic_unit_normal_q <= reg_wdata_in[15:0];
					end
					`CIA_REG_AWP:
					begin
						atomic_unit_powerfail_q <= reg_wdata_in[15:0];
					end
					`CIA_REG_NPS:
					begin
						power_state_count_q <= reg_wdata_in[4:0];
					end
					`CIA_REG_PSIDX:
					begin
						ps_idx_q <= reg_wdata_in[4:0];
					end
					`CIA_REG_VSIDX:
					begin
						vs_idx_q <= reg_wdata_in[7:0];
					end
					`CIA_REG_RDADDR:
					begin
						rd_addr_q <= reg_wdata_in[11:0];
					end
					default:
					begin
						rd_addr_q <= rd_addr_q;
					end
				endcase
			end
		end
	end

	// Descriptor and implementation-defined storage
	always @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			for (i = 0; i < 32; i = i + 1)
			begin
				max_power_field[i] <= 16'h0000;
				entry_latency_field[i] <= 32'h0000_0000;
				exit_latency_field[i] <= 32'h0000_0000;
				rel_rank[i] <= 20'h00000;
			end
		end
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				`CIA_REG_PSMP:
				begin
					max_power_field[ps_idx_q] <= reg_wdata_in[15:0];
				end
				`CIA_REG_PSEN:
				begin
					entry_latency_field[ps_idx_q] <= reg_wdata_in;
				end
				`CIA_REG_PSEX:
				begin
					exit_latency_field[ps_idx_q] <= reg_wdata_in;
				end
				`CIA_REG_PSREL:
				begin
					rel_rank[ps_idx_q] <= {
						cia_rank(reg_wdata_in[19:15], power_state_count_q),
						cia_rank(reg_wdata_in[14:10], power_state_count_q),
						cia_rank(reg_wdata_in[9:5], power_state_count_q),
						cia_rank(reg_wdata_in[4:0], power_state_count_q)};
				end
				default:
				begin
					max_power_field[0] <= max_power_field[0];
				end
			endcase
		end
	end

	always @(posedge clk_sys_in)
	begin
		if (reg_wr_in && reg_addr_in == `CIA_REG_VSDAT)
			vs_mem[vs_idx_q % VS_WORDS] <= reg_wdata_in;
	end
endmodule
`default_nettype wire

// ---- tb/cia_attr_monitor.sv ----
// Port checker for the identify attribute block
`default_nettype none
`include "cia_defines.vh"
module cia_attr_monitor (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic write_cache_present_out,
	input wire logic [15:0] atomic_unit_normal_out,
	input wire logic [15:0] atomic_unit_powerfail_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	idle_data_zero_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
		else $error("read data not zero when idle");
	unmapped_read_a: assert property (reg_rd_in && reg_addr_in > `CIA_REG_RDDATA |=>
		reg_rdata_out == 32'h0) else $error("unmapped read not zero");
	byte_read_a: assert property (reg_rd_in && reg_addr_in == `CIA_REG_RDDATA |=>
		reg_rdata_out[31:8] == 24'h0) else $error("byte read too wide");
	fmt_reserved_a: assert property (reg_rd_in && reg_addr_in == `CIA_REG_FMT |=>
		reg_rdata_out[31:3] == 29'h0) else $error("format reserved bits set");
	count_width_a: assert property (reg_rd_in && reg_addr_in == `CIA_REG_NPS |=>
		reg_rdata_out[31:5] == 27'h0) else $error("state count too wide");
	cache_echo_a: assert property (reg_wr_in && reg_addr_in == `CIA_REG_CACHE ##2
		reg_rd_in && reg_addr_in == `CIA_REG_CACHE |=>
		reg_rdata_out == {31'h0, $past(reg_wdata_in[0], 3)}) else $error("cache bit lost");
	cache_hold_a: assert property ($changed(write_cache_present_out) |->
		$past(reg_wr_in) || $past(reg_wr_in, 2)) else $error("cache bit moved");
	normal_hold_a: assert property ($changed(atomic_unit_normal_out) |->
		$past(reg_wr_in) || $past(reg_wr_in, 2)) else $error("normal size moved");
	pfail_hold_a: assert property ($changed(atomic_unit_powerfail_out) |->
		$past(reg_wr_in) || $past(reg_wr_in, 2)) else $error("powerfail size moved");
	cover property (reg_rd_in && reg_addr_in == `CIA_REG_RDDATA);
	cover property (reg_wr_in && reg_addr_in == `CIA_REG_CACHE);
	cover property (reg_wr_in && reg_addr_in == `CIA_REG_PSREL);
endmodule
bind cia_identify_attr cia_attr_monitor cia_attr_monitor_inst (.clk_sys_in, .resetn_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.write_cache_present_out, .atomic_unit_normal_out, .atomic_unit_powerfail_out);
`default_nettype wire

// ---- tb/cia_host_model.sv ----
// Host side model issuing register and structure accesses
`default_nettype none
`include "cia_defines.vh"
module cia_host_model (
	input wire logic clk_sys_in,
	input wire logic [31:0] reg_rdata_in,
	input wire logic cache_present_in,
	output logic [11:0] reg_addr_out,
	output logic [31:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic may_flush;
	assign may_flush = cache_present_in;
	initial
	begin
		reg_addr_out = 12'h000;
		reg_wdata_out = 32'h0;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_out <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		@(posedge clk_sys_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_out <= 1'b0;
		#1 q = reg_rdata_in;
	endtask
	task automatic rdb(input logic [11:0] a, output logic [31:0] q);
		wr(`CIA_REG_RDADDR, {20'h0, a});
		rd(`CIA_REG_RDDATA, q);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the identify attribute block
`default_nettype none
`include "cia_defines.vh"
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	wire logic [11:0] addr;
	wire logic [31:0] wdata;
	wire logic [31:0] rdata;
	wire logic wr;
	wire logic rd;
	wire logic cache;
	wire logic [15:0] awn;
	wire logic [15:0] awp;
	int bad_count = 0;
	int num_checks = 0;
	logic [31:0] q;
	always #2 clk_sys_in = ~clk_sys_in;
	cia_identify_attr #(.VS_WORDS(16)) cia_identify_attr_inst (.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .write_cache_present_out(cache),
		.atomic_unit_normal_out(awn), .atomic_unit_powerfail_out(awp));
	cia_host_model cia_host_model_inst (.clk_sys_in(clk_sys_in), .reg_rdata_in(rdata),
		.cache_present_in(cache), .reg_addr_out(addr), .reg_wdata_out(wdata),
		.reg_wr_out(wr), .reg_rd_out(rd));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [11:0] a, input logic [31:0] d);
		cia_host_model_inst.wr(a, d);
	endtask
	task automatic rb(input logic [11:0] a, input logic [31:0] exp);
		cia_host_model_inst.rdb(a, q);
		cmp(q, exp);
	endtask
	task automatic t_fmt;
		w(`CIA_REG_FMT, 32'hFFFFFFFF);
		rb(12'h20C, 32'h07);
		w(`CIA_REG_FMT, 32'h5);
		rb(12'h20C, 32'h05);
		w(`CIA_REG_FMT, 32'h2);
		rb(12'h20C, 32'h02);
	endtask
	task automatic t_cache;
		w(`CIA_REG_CACHE, 32'hFF);
		cia_host_model_inst.rd(`CIA_REG_CACHE, q);
		cmp(q, 32'h1);
		cmp({31'h0, cache}, 32'h1);
		cmp({31'h0, cia_host_model_inst.may_flush}, 32'h1);
		rb(12'h20D, 32'h01);
	endtask
	task automatic t_atomic;
		w(`CIA_REG_AWN, 32'h1234);
		w(`CIA_REG_AWP, 32'hABCD);
		rb(12'h20E, 32'h34);
		rb(12'h20F, 32'h12);
		rb(12'h210, 32'hCD);
		rb(12'h211, 32'hAB);
		cmp({awp, awn}, 32'hABCD1234);
	endtask
	task automatic t_psd;
		w(`CIA_REG_NPS, 32'h1);
		w(`CIA_REG_PSIDX, 32'h1);
		w(`CIA_REG_PSMP, 32'h0102);
		w(`CIA_REG_PSEN, 32'h11223344);
		w(`CIA_REG_PSEX, 32'h55667788);
		w(`CIA_REG_PSREL, 32'hFFFFF);
		w(`CIA_REG_PSIDX, 32'h0);
		w(`CIA_REG_PSMP, 32'h00AA);
		rb(12'h107, 32'h01);
		rb(12'h800, 32'hAA);
		rb(12'h820, 32'h02);
		rb(12'h821, 32'h01);
		rb(12'h822, 32'h00);
		rb(12'h824, 32'h44);
		rb(12'h82B, 32'h55);
		rb(12'h82C, 32'h01);
		rb(12'h82F, 32'h01);
		rb(12'h840, 32'h00);
	endtask
	task automatic t_vs;
		w(`CIA_REG_VSIDX, 32'h0);
		w(`CIA_REG_VSDAT, 32'hA1B2C3D4);
		rb(12'hC00, 32'hD4);
		rb(12'hC03, 32'hA1);
		rb(12'h2C0, 32'h00);
		cia_host_model_inst.rd(12'h300, q);
		cmp(q, 32'h0);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		@(posedge clk_sys_in);
		cmp({31'h0, cache}, 32'h0);
		cmp({31'h0, cia_host_model_inst.may_flush}, 32'h0);
		cmp({16'h0, awn}, 32'h00FF);
		cmp({16'h0, awp}, 32'h0);
		t_fmt;
		t_cache;
		t_atomic;
		t_psd;
		t_vs;
		results;
	end
endmodule
`default_nettype wire
